//--- logic/gpasp_cfg.svh
// Constants for the shared analog/digital pin port: offsets, reset values, widths
`ifndef GPASP_CFG_SVH
`define GPASP_CFG_SVH
`define GPASP_NPINS 16
`define GPASP_AW 4
`define GPASP_OFS_DIR 4'h0
`define GPASP_OFS_PORT 4'h1
`define GPASP_OFS_LAT 4'h2
`define GPASP_OFS_ANSEL 4'h3
`define GPASP_OFS_PU 4'h4
`define GPASP_OFS_PD 4'h5
`define GPASP_OFS_ALT_EN 4'h6
`define GPASP_OFS_STATUS 4'h7
`define GPASP_RST_DIR 16'hFFFF
`define GPASP_RST_LAT 16'h0000
`define GPASP_RST_ANSEL 16'hFFFF
`define GPASP_RST_PU 16'h0000
`define GPASP_RST_PD 16'h0000
`define GPASP_RST_ALT_EN 16'h0000
`define GPASP_ANALOG_MASK 16'hFFFF
`endif

//--- logic/gpasp_pkg.sv
// Types for the shared analog/digital pin port
package gpasp_pkg;
    typedef logic [15:0] gpasp_word_t;
    typedef logic [3:0] gpasp_addr_t;
    typedef enum logic [1:0] {
        GPASP_FN_ANALOG,
        GPASP_FN_ALT,
        GPASP_FN_GPIO
    } gpasp_fn_t;
endpackage : gpasp_pkg

//--- logic/gpasp_pin_sync.sv
// Two-flop synchroniser for the pin inputs and the over-voltage detect level
module gpasp_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : gpasp_pin_sync

//--- logic/gpasp_port.sv
// Shared analog/digital general-purpose pin port with register access
// Behaviour
// - After any reset, every analog-capable pin comes up in analog mode.
// - Analog pin: digital input buffer off, port and latch reads return zero.
// - Writing zero to a pin's analog select bit makes it digital I/O.
// - Output driver still works in analog mode when direction is output.
// - Highest-priority enabled function owns the pin; lower ones have no effect, except that the port driver still acts under analog.
// - Each pin has independent pull-up and pull-down enable bits.
// - Over-voltage detect tri-states every pin while it is asserted.
`include "gpasp_cfg.svh"
module gpasp_port (
    input wire logic clk,
    input wire logic nrst,
    input wire gpasp_pkg::gpasp_addr_t addr,
    input wire gpasp_pkg::gpasp_word_t wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output gpasp_pkg::gpasp_word_t rdata,
    input wire gpasp_pkg::gpasp_word_t pin_in,
    output gpasp_pkg::gpasp_word_t pin_out,
    output gpasp_pkg::gpasp_word_t pin_oe,
    output gpasp_pkg::gpasp_word_t pullup_en,
    output gpasp_pkg::gpasp_word_t pulldown_en,
    output gpasp_pkg::gpasp_word_t analog_connect,
    output gpasp_pkg::gpasp_word_t dig_in_enable,
    input wire gpasp_pkg::gpasp_word_t alt_out,
    input wire gpasp_pkg::gpasp_word_t alt_oe,
    output gpasp_pkg::gpasp_word_t alt_in,
    input wire logic core_overvoltage_detect
);
    import gpasp_pkg::*;

    gpasp_word_t direction_control_r;
    gpasp_word_t output_latch_r;
    gpasp_word_t analog_select_r;
    gpasp_word_t pullup_enable_r;
    gpasp_word_t pulldown_enable_r;
    gpasp_word_t alt_enable_r;
    gpasp_word_t pin_sync;
    gpasp_word_t rdata_nxt;
    logic ovd_sync;
    gpasp_word_t pin_out_nxt;
    gpasp_word_t pin_oe_nxt;

    // Per-pin owner after left-to-right priority: analog, then alternate, then port
    function automatic gpasp_fn_t pin_owner(input logic an, input logic alt);
        if (an) begin
            return GPASP_FN_ANALOG;
        end else if (alt) begin
            return GPASP_FN_ALT;
        end
        return GPASP_FN_GPIO;
    endfunction : pin_owner

    gpasp_pin_sync #(
        .W(`GPASP_NPINS + 1)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({core_overvoltage_detect, pin_in}),
        .sync_out({ovd_sync, pin_sync})
    );

    wire logic wr_hit = wr_stb;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            analog_select_r <= `GPASP_RST_ANSEL;
        end else if (wr_hit && addr == `GPASP_OFS_ANSEL) begin
            // Only analog-capable pins may leave a 1 here
            analog_select_r <= wdata & `GPASP_ANALOG_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            direction_control_r <= `GPASP_RST_DIR;
            output_latch_r <= `GPASP_RST_LAT;
            alt_enable_r <= `GPASP_RST_ALT_EN;
        end else if (wr_hit) begin
            case (addr)
                `GPASP_OFS_DIR: direction_control_r <= wdata;
                `GPASP_OFS_LAT: output_latch_r <= wdata;
                // Port writes land in the latch, as usual for such ports
                `GPASP_OFS_PORT: output_latch_r <= wdata;
                `GPASP_OFS_ALT_EN: alt_enable_r <= wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pullup_enable_r <= `GPASP_RST_PU;
            pulldown_enable_r <= `GPASP_RST_PD;
        end else if (wr_hit) begin
            if (addr == `GPASP_OFS_PU) begin
                pullup_enable_r <= wdata;
            end
            if (addr == `GPASP_OFS_PD) begin
                pulldown_enable_r <= wdata;
            end
        end
    end

    // Pin drive: analog still lets the port driver act on output direction
    always_comb begin
        pin_out_nxt = '0;
        pin_oe_nxt = '0;
        for (int i = 0; i < `GPASP_NPINS; i++) begin
            case (pin_owner(analog_select_r[i], alt_enable_r[i]))
                GPASP_FN_ANALOG: begin
                    pin_out_nxt[i] = output_latch_r[i];
                    pin_oe_nxt[i] = ~direction_control_r[i];
                end
                GPASP_FN_ALT: begin
                    pin_out_nxt[i] = alt_out[i];
                    pin_oe_nxt[i] = alt_oe[i];
                end
                GPASP_FN_GPIO: begin
                    pin_out_nxt[i] = output_latch_r[i];
                    pin_oe_nxt[i] = ~direction_control_r[i];
                end
                default: begin
                    pin_out_nxt[i] = 1'b0;
                    pin_oe_nxt[i] = 1'b0;
                end
            endcase
        end
        if (ovd_sync) begin
            pin_oe_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_out <= '0;
            pin_oe <= '0;
            pullup_en <= '0;
            pulldown_en <= '0;
            analog_connect <= '0;
            dig_in_enable <= '0;
            alt_in <= '0;
        end else begin
            pin_out <= pin_out_nxt;
            pin_oe <= pin_oe_nxt;
            // Pulls are released too so a tri-stated pin really floats
            pullup_en <= ovd_sync ? '0 : pullup_enable_r;
            pulldown_en <= ovd_sync ? '0 : pulldown_enable_r;
            analog_connect <= analog_select_r;
            dig_in_enable <= ~analog_select_r;
            // Alternate input only sees the pin while it owns it
            alt_in <= pin_sync & alt_enable_r & ~analog_select_r;
        end
    end

    always_comb begin
        rdata_nxt = '0;
        case (addr)
            `GPASP_OFS_DIR: rdata_nxt = direction_control_r;
            `GPASP_OFS_PORT: rdata_nxt = pin_sync & ~analog_select_r;
            `GPASP_OFS_LAT: rdata_nxt = output_latch_r & ~analog_select_r;
            `GPASP_OFS_ANSEL: rdata_nxt = analog_select_r;
            `GPASP_OFS_PU: rdata_nxt = pullup_enable_r;
            `GPASP_OFS_PD: rdata_nxt = pulldown_enable_r;
            `GPASP_OFS_ALT_EN: rdata_nxt = alt_enable_r;
            `GPASP_OFS_STATUS: rdata_nxt = {15'h0000, ovd_sync};
            default: rdata_nxt = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata <= '0;
        end else if (rd_stb) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= '0;
        end
    end
endmodule : gpasp_port

//--- testbench/gpasp_port_properties.sv
// Port-level assertions for the shared analog/digital pin port
module gpasp_port_properties (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic core_overvoltage_detect,
    input wire gpasp_pkg::gpasp_addr_t addr,
    input wire gpasp_pkg::gpasp_word_t wdata,
    input wire gpasp_pkg::gpasp_word_t rdata,
    input wire gpasp_pkg::gpasp_word_t pin_in,
    input wire gpasp_pkg::gpasp_word_t pin_oe,
    input wire gpasp_pkg::gpasp_word_t pullup_en,
    input wire gpasp_pkg::gpasp_word_t analog_connect,
    input wire gpasp_pkg::gpasp_word_t dig_in_enable,
    input wire gpasp_pkg::gpasp_word_t alt_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpasp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Four samples span both sync flops and the output register
    property p_ovd; core_overvoltage_detect [*4] |-> (pin_oe | pullup_en) == 16'h0000;
    endproperty
    a_ovd: assert property (p_ovd) else $error("pins driven in overvoltage");
    property p_idle; !$past(rd_stb) |-> rdata == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    property p_rst; $rose(nrst) |-> ##2 analog_connect == 16'hFFFF && dig_in_enable == 16'h0000;
    endproperty
    a_rst: assert property (p_rst) else $error("not analog after reset");
    property p_dig; $past(nrst) && $past(nrst, 2) |-> dig_in_enable == ~analog_connect;
    endproperty
    a_dig: assert property (p_dig) else $error("input buffer mismatch");
    property p_alt; (alt_in & analog_connect) == 16'h0000; endproperty
    a_alt: assert property (p_alt) else $error("peripheral sees analog pin");
    property p_port; $stable(pin_in) [*3] ##0 rd_stb && addr == 4'h1
        |=> rdata == ($past(pin_in) & ~analog_connect); endproperty
    a_port: assert property (p_port) else $error("port read wrong");
    property p_lat; rd_stb && addr == 4'h2 |=> (rdata & analog_connect) == 16'h0000;
    endproperty
    a_lat: assert property (p_lat) else $error("latch read unmasked");
    property p_pu; !core_overvoltage_detect [*3] ##0 wr_stb && addr == 4'h4
        |-> ##2 pullup_en == $past(wdata, 2); endproperty
    a_pu: assert property (p_pu) else $error("pull-up enable wrong");
    c_ovd: cover property (core_overvoltage_detect [*4]);
    c_port: cover property (rd_stb && addr == 4'h1);
    c_alt: cover property (alt_in != 16'h0000);
endmodule : gpasp_port_properties
bind gpasp_port gpasp_port_properties u_props (.*);

//--- testbench/gpasp_port_test.sv
// Self-checking bench for the shared analog/digital pin port
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module gpasp_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import gpasp_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, rd_d = 1'b0;
    logic core_overvoltage_detect = 1'b0;
    gpasp_addr_t addr = '0;
    gpasp_word_t wdata = '0, pin_in = '0, alt_out = '0, alt_oe = '0, m, l, p, d, e, x, q[$];
    gpasp_word_t rdata, pin_out, pin_oe, pullup_en, pulldown_en, analog_connect;
    gpasp_word_t dig_in_enable, alt_in;
    int miscompares = 0, total_checks = 0;
    gpasp_port u_dut (.*);
    task automatic give_verdict();
        $display("checks %0d, miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    // A read notes its expected word; the monitor pairs it with rdata
    task automatic bus(input logic w, input gpasp_addr_t a, input gpasp_word_t v);
        if (!w) q.push_back(v);
        wr_stb <= w;
        rd_stb <= !w;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        @(posedge clk);
    endtask : bus
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rd_d) begin
            x = q.pop_front();
            `CHK(rdata, x)
        end
        rd_d <= rd_stb;
    end
    initial begin
        void'($urandom(68));
        pin_in = 16'($urandom);
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        bus(0, 4'h0, 16'hFFFF);
        bus(0, 4'h3, 16'hFFFF);
        bus(0, 4'h1, 16'h0000);
        bus(0, 4'h9, 16'h0000);
        $display("reset test done");
        m = 16'($urandom);
        l = 16'($urandom);
        p = 16'($urandom);
        pin_in <= p;
        bus(1, 4'h3, m);
        bus(1, 4'h2, l);
        bus(0, 4'h1, p & ~m);
        bus(0, 4'h2, l & ~m);
        `CHK(dig_in_enable, ~m)
        $display("digital test done");
        d = 16'($urandom);
        e = 16'($urandom);
        alt_oe <= 16'($urandom);
        alt_out <= 16'($urandom);
        bus(1, 4'h0, d);
        @(posedge clk);
        `CHK(pin_oe, ~d)
        `CHK(pin_out & ~d, l & ~d)
        bus(1, 4'h6, e);
        @(posedge clk);
        d = (~d & ~(e & ~m)) | (alt_oe & e & ~m);
        `CHK(pin_oe, d)
        `CHK(alt_in, p & e & ~m)
        $display("drive test done");
        m = 16'($urandom);
        l = 16'($urandom);
        bus(1, 4'h4, m);
        bus(1, 4'h5, l);
        bus(0, 4'h4, m);
        bus(0, 4'h5, l);
        `CHK({pullup_en, pulldown_en}, {m, l})
        $display("pull test done");
        core_overvoltage_detect <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK(pin_oe | pullup_en | pulldown_en, 16'h0000)
        bus(0, 4'h7, 16'h0001);
        core_overvoltage_detect <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK(pin_oe, d)
        $display("overvoltage test done");
        give_verdict();
    end
    // The tests need about fifty cycles; this is far beyond that
    initial begin
        #20000;
        miscompares++;
        give_verdict();
    end
endmodule : gpasp_port_test
